// *** core/regs_pkg.sv ***
package regs_pkg;

  // ----------------------------------------------------------------
  // register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_STATUS  = 8'h0c;
  localparam logic [7:0] IDX_MASK    = 8'h0d;
  localparam logic [7:0] IDX_DELAY   = 8'h0e;
  localparam logic [7:0] IDX_KEY     = 8'h10;
  localparam logic [7:0] IDX_CONFIG  = 8'h11;
  localparam logic [7:0] IDX_SCRATCH = 8'h20;

  localparam logic [7:0] ADDR_STATUS  = {IDX_STATUS[5:0], 2'b00};
  localparam logic [7:0] ADDR_MASK    = {IDX_MASK[5:0], 2'b00};
  localparam logic [7:0] ADDR_DELAY   = {IDX_DELAY[5:0], 2'b00};
  localparam logic [7:0] ADDR_KEY     = {IDX_KEY[5:0], 2'b00};
  localparam logic [7:0] ADDR_CONFIG  = {IDX_CONFIG[5:0], 2'b00};
  localparam logic [7:0] ADDR_SCRATCH = {IDX_SCRATCH[5:0], 2'b00};

  // ----------------------------------------------------------------
  // reset values, keys, field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_STATUS  = 8'h00;
  localparam logic [7:0] RST_MASK    = 8'hdf;
  localparam logic [7:0] RST_DELAY   = 8'h07;
  localparam logic [7:0] RST_KEY     = 8'h00;
  localparam logic [7:0] RST_CONFIG  = 8'h00;
  localparam logic [7:0] RST_SCRATCH = 8'h00;

  localparam logic [7:0] KEY_FIRST   = 8'hba;
  localparam logic [7:0] KEY_SECOND  = 8'hbe;
  localparam logic [7:0] KEY_RELOCK  = 8'h00;

  localparam int BIT_LED_OVP      = 7;
  localparam int BIT_REG_PG       = 6;
  localparam int BIT_PROJ_ON      = 5;
  localparam int BIT_ARRAY_REG    = 4;
  localparam int BIT_UNDERVOLTAGE = 3;
  localparam int BIT_LOW_BATTERY  = 2;
  localparam int BIT_THERM_SHUT   = 1;
  localparam int BIT_THERM_WARN   = 0;

  localparam int OFFSET_DELAY_LSB = 4;
  localparam int BIAS_DELAY_LSB   = 0;
  localparam int CFG_NV_PROGRAM   = 2;
  localparam int CFG_DIRECT_MODE  = 1;

  // ----------------------------------------------------------------
  // timing: delays counted in ticks of 0.1 us
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 100;
  localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [13:0] DELAY_TENTHS_US [16] = '{
    14'h0028, 14'h0050, 14'h00a0, 14'h0140, 14'h0280, 14'h0500, 14'h0a00, 14'h1400,
    14'h003e, 14'h007c, 14'h00f9, 14'h01f2, 14'h03e3, 14'h07c7, 14'h0f8f, 14'h2802
  };

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LOCKED, KEY_HALF, UNLOCKED} lock_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic bias_rail_en;
    logic negative_reset_rail_en;
    logic offset_rail_en;
    logic array_reset_n;
  } rails_t;

  typedef struct packed {
    logic       program_pulse;
    logic [7:0] data;
  } nvm_t;

  typedef struct packed {
    apb_rsp_t    apb;
    logic [7:0]  status;
    logic [7:0]  mask;
    logic [7:0]  delay;
    logic [7:0]  key;
    logic [7:0]  config_bits;
    logic [7:0]  scratch;
    lock_state_t lock;
    logic        irq;
    nvm_t        nvm;
    rails_t      rails;
    logic [7:0]  tick_cnt;
    logic        tick;
    logic [13:0] bias_cnt;
    logic [13:0] offset_cnt;
  } state_t;

endpackage : regs_pkg

// *** core/pmic_mask_timing_unlock_regs.sv ***
// Design decision made here: the APB slave port.
module pmic_mask_timing_unlock_regs #(
  parameter logic [7:0] tick_cycles = 8'(regs_pkg::TICK_CYCLES)
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire regs_pkg::apb_req_t apb_req,
  output      regs_pkg::apb_rsp_t apb_rsp,
  input  wire logic [7:0]        fault_flags,
  input  wire logic              rails_enable,
  output      logic              irq,
  output      logic              direct_mode,
  output      regs_pkg::nvm_t    nvm,
  output      regs_pkg::rails_t  rails
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [13:0] delay_ticks(input logic [3:0] code);
    delay_ticks = regs_pkg::DELAY_TENTHS_US[code];
  endfunction : delay_ticks

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == regs_pkg::ADDR_STATUS) || (a == regs_pkg::ADDR_MASK) ||
               (a == regs_pkg::ADDR_DELAY) || (a == regs_pkg::ADDR_KEY) ||
               (a == regs_pkg::ADDR_CONFIG) || (a == regs_pkg::ADDR_SCRATCH);
  endfunction : addr_hit

  regs_pkg::state_t state_reg;
  regs_pkg::state_t state_next;

  logic       setup_phase;
  logic       write_take;
  logic [7:0] wdata;
  logic [3:0] bias_code;
  logic [3:0] offset_code;

  assign setup_phase = apb_req.psel && !apb_req.penable && !state_reg.apb.pready;
  assign write_take  = apb_req.psel && apb_req.penable && state_reg.apb.pready && apb_req.pwrite &&
                       addr_hit(apb_req.paddr);
  assign wdata       = apb_req.pwdata[7:0];
  assign bias_code   = state_reg.delay[regs_pkg::BIAS_DELAY_LSB +: 4];
  assign offset_code = state_reg.delay[regs_pkg::OFFSET_DELAY_LSB +: 4];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.nvm.program_pulse = 1'b0;

    // apb answer: one access cycle, no wait states
    state_next.apb.pready = setup_phase;
    if (setup_phase) begin
      state_next.apb.pslverr = !addr_hit(apb_req.paddr);
      state_next.apb.prdata  = 32'h0000_0000;
      if (!apb_req.pwrite) begin
        unique case (apb_req.paddr)
          regs_pkg::ADDR_STATUS:  state_next.apb.prdata[7:0] = state_reg.status;
          regs_pkg::ADDR_MASK:    state_next.apb.prdata[7:0] = state_reg.mask;
          regs_pkg::ADDR_DELAY:   state_next.apb.prdata[7:0] = state_reg.delay;
          regs_pkg::ADDR_KEY:     state_next.apb.prdata[7:0] = state_reg.key;
          regs_pkg::ADDR_CONFIG:  state_next.apb.prdata[7:0] = state_reg.config_bits;
          regs_pkg::ADDR_SCRATCH: state_next.apb.prdata[7:0] = state_reg.scratch;
          default:                state_next.apb.prdata      = 32'h0000_0000;
        endcase
      end
    end else if (!apb_req.psel) begin
      state_next.apb.pslverr = 1'b0;
    end

    // register writes at the access edge
    if (write_take) begin
      unique case (apb_req.paddr)
        regs_pkg::ADDR_MASK: begin
          state_next.mask = wdata;
        end
        regs_pkg::ADDR_DELAY: begin
          state_next.delay = wdata;
        end
        regs_pkg::ADDR_KEY: begin
          state_next.key = wdata;
          unique case (state_reg.lock)
            regs_pkg::LOCKED: begin
              state_next.lock = (wdata == regs_pkg::KEY_FIRST) ? regs_pkg::KEY_HALF : regs_pkg::LOCKED;
            end
            regs_pkg::KEY_HALF: begin
              if (wdata == regs_pkg::KEY_SECOND) begin
                state_next.lock = regs_pkg::UNLOCKED;
              end else if (wdata == regs_pkg::KEY_FIRST) begin
                state_next.lock = regs_pkg::KEY_HALF;
              end else begin
                state_next.lock = regs_pkg::LOCKED;
              end
            end
            regs_pkg::UNLOCKED: begin
              if (wdata == regs_pkg::KEY_RELOCK) begin
                state_next.lock = regs_pkg::LOCKED;
              end
            end
            default: begin
              state_next.lock = regs_pkg::LOCKED;
            end
          endcase
        end
        regs_pkg::ADDR_CONFIG: begin
          if (state_reg.lock == regs_pkg::UNLOCKED) begin
            state_next.config_bits = wdata;
            if (wdata[regs_pkg::CFG_NV_PROGRAM]) begin
              state_next.nvm.program_pulse = 1'b1;
              state_next.nvm.data          = state_reg.scratch;
            end
          end
        end
        regs_pkg::ADDR_SCRATCH: begin
          state_next.scratch = wdata;
        end
        default: begin
          state_next.scratch = state_reg.scratch;
        end
      endcase
    end

    // status follows the fault sources
    state_next.status = fault_flags;

    // interrupt gating, one mask bit per status bit
    state_next.irq = |(state_reg.status & ~state_reg.mask);

    // 0.1 us tick divider, held in phase while rails are off
    state_next.tick = 1'b0;
    if (!rails_enable) begin
      state_next.tick_cnt = 8'h00;
    end else if (state_reg.tick_cnt == tick_cycles - 8'h01) begin
      state_next.tick_cnt = 8'h00;
      state_next.tick     = 1'b1;
    end else begin
      state_next.tick_cnt = state_reg.tick_cnt + 8'h01;
    end

    // rail sequencing: bias and negative rail first, then offset and reset
    if (!rails_enable) begin
      state_next.bias_cnt   = 14'h0000;
      state_next.offset_cnt = 14'h0000;
      state_next.rails      = '0;
    end else if (state_reg.tick) begin
      if (!state_reg.rails.bias_rail_en) begin
        if (state_reg.bias_cnt + 14'h0001 >= delay_ticks(bias_code)) begin
          state_next.rails.bias_rail_en           = 1'b1;
          state_next.rails.negative_reset_rail_en = 1'b1;
        end else begin
          state_next.bias_cnt = state_reg.bias_cnt + 14'h0001;
        end
      end else if (!state_reg.rails.offset_rail_en) begin
        if (state_reg.offset_cnt + 14'h0001 >= delay_ticks(offset_code)) begin
          state_next.rails.offset_rail_en = 1'b1;
          state_next.rails.array_reset_n  = 1'b1;
        end else begin
          state_next.offset_cnt = state_reg.offset_cnt + 14'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg             <= '0;
      state_reg.status      <= regs_pkg::RST_STATUS;
      state_reg.mask        <= regs_pkg::RST_MASK;
      state_reg.delay       <= regs_pkg::RST_DELAY;
      state_reg.key         <= regs_pkg::RST_KEY;
      state_reg.config_bits <= regs_pkg::RST_CONFIG;
      state_reg.scratch     <= regs_pkg::RST_SCRATCH;
      state_reg.lock        <= regs_pkg::LOCKED;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign apb_rsp     = state_reg.apb;
  assign irq         = state_reg.irq;
  assign direct_mode = state_reg.config_bits[regs_pkg::CFG_DIRECT_MODE];
  assign nvm         = state_reg.nvm;
  assign rails       = state_reg.rails;

endmodule : pmic_mask_timing_unlock_regs

// *** tb/regs_checker_assertions.sv ***
module regs_checker (
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire regs_pkg::apb_req_t apb_req,
  input wire regs_pkg::apb_rsp_t apb_rsp,
  input wire logic [7:0]         fault_flags,
  input wire logic               rails_enable,
  input wire logic               irq,
  input wire logic               direct_mode,
  input wire regs_pkg::nvm_t     nvm,
  input wire regs_pkg::rails_t   rails
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // port checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic setup, mapped, cfg_wr, nv_wr;
  assign setup  = apb_req.psel && !apb_req.penable;
  assign mapped = apb_req.paddr inside {8'h30, 8'h34, 8'h38, 8'h40, 8'h44, 8'h80};
  assign cfg_wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == 8'h44;
  assign nv_wr  = cfg_wr && apb_req.pwdata[2];

  ready_once_a: assert property (setup |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("pready not one cycle after setup");
  unmapped_err_a: assert property (setup && !mapped && !apb_req.pwrite |=>
    apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("unmapped read not refused");
  read_width_a: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h0)
    else $error("read data above bit 7");
  irq_quiet_a: assert property ((fault_flags == 8'h00) [*3] |-> !irq)
    else $error("irq without any fault");
  irq_cause_a: assert property (irq |-> $past(fault_flags, 2) != 8'h00)
    else $error("irq not caused by a flag");
  pulse_once_a: assert property (nvm.program_pulse |=> !nvm.program_pulse)
    else $error("program pulse too long");
  pulse_cause_a: assert property ($rose(nvm.program_pulse) |-> $past(nv_wr) || $past(nv_wr, 2))
    else $error("program pulse without config write");
  direct_cause_a: assert property ($changed(direct_mode) |-> $past(cfg_wr) || $past(cfg_wr, 2))
    else $error("direct mode changed alone");
  rails_off_a: assert property (!rails_enable |=> rails == 4'h0)
    else $error("rails on while disabled");
  rail_order_a: assert property (rails.offset_rail_en |-> rails.bias_rail_en)
    else $error("offset rail before bias rail");
endmodule : regs_checker

bind pmic_mask_timing_unlock_regs regs_checker chk_u (.clk, .sys_rst, .apb_req, .apb_rsp,
  .fault_flags, .rails_enable, .irq, .direct_mode, .nvm, .rails);

// *** tb/host_model.sv ***
module host_model (
  input  wire logic               clk,
  input  wire logic               go,
  input  wire logic               wr,
  input  wire logic [7:0]         addr,
  input  wire logic [31:0]        wdata,
  output      regs_pkg::apb_req_t req,
  input  wire regs_pkg::apb_rsp_t rsp,
  output      logic               done,
  output      logic [31:0]        rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // apb master: setup, access until pready, then release
  // ----------------------------------------------------------------
  initial begin
    req   = '0;
    done  = 1'b0;
    rdata = '0;
  end
  always @(posedge clk) begin
    done <= 1'b0;
    if (req.psel && req.penable && rsp.pready) begin
      rdata <= rsp.prdata;
      done  <= 1'b1;
      req   <= {2'b00, ~req[40:0]};
    end else if (req.psel) req.penable <= 1'b1;
    else if (go) req <= {1'b1, 1'b0, wr, addr, wdata};
  end
endmodule : host_model

// *** tb/pmic_mask_timing_unlock_regs_test.sv ***
module pmic_mask_timing_unlock_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk, sys_rst, go, wr, done, rails_enable, irq, direct_mode;
  logic [7:0]         addr, fault_flags, v;
  logic [31:0]        wdata, rdata;
  regs_pkg::apb_req_t apb_req;
  regs_pkg::apb_rsp_t apb_rsp;
  regs_pkg::nvm_t     nvm;
  regs_pkg::rails_t   rails;
  logic [7:0]         exp_q[$];
  int                 err_count, checks, pulses, cycles, seed;

  pmic_mask_timing_unlock_regs #(.tick_cycles(8'h01)) dut_u (.clk, .sys_rst, .apb_req, .apb_rsp,
    .fault_flags, .rails_enable, .irq, .direct_mode, .nvm, .rails);
  host_model host_u (.clk, .go, .wr, .addr, .wdata, .req(apb_req), .rsp(apb_rsp), .done, .rdata);

  // ----------------------------------------------------------------
  // tasks and monitors
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [7:0] e);
    @(posedge clk);
    go <= 1'b1; wr <= w; addr <= a; wdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge clk);
    go <= 1'b0;
    do @(negedge clk); while (done !== 1'b1);
  endtask : xfer

  task automatic print_verdict;
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  always @(negedge clk) if (done === 1'b1 && wr === 1'b0) check(rdata, {24'h0, exp_q.pop_front()});
  always @(negedge clk) if (nvm.program_pulse === 1'b1) pulses++;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1; go = 1'b0; wr = 1'b0; addr = '0; wdata = '0;
    fault_flags = '0; rails_enable = 1'b0; seed = 64;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    xfer(1'b0, regs_pkg::ADDR_MASK, 0, 8'hdf);
    xfer(1'b0, regs_pkg::ADDR_DELAY, 0, 8'h07);
    xfer(1'b0, regs_pkg::ADDR_KEY, 0, 8'h00);
    xfer(1'b0, regs_pkg::ADDR_CONFIG, 0, 8'h00);
    xfer(1'b0, regs_pkg::ADDR_SCRATCH, 0, 8'h00);
    xfer(1'b0, regs_pkg::ADDR_STATUS, 0, 8'h00);
    xfer(1'b0, 8'h3c, 0, 8'h00);
    for (int i = 0; i < 3; i++) begin
      v = 8'($random(seed));
      xfer(1'b1, regs_pkg::ADDR_SCRATCH, {24'h0, v}, 0);
      xfer(1'b0, regs_pkg::ADDR_SCRATCH, 0, v);
    end
    xfer(1'b1, regs_pkg::ADDR_CONFIG, 32'h06, 0);
    xfer(1'b1, regs_pkg::ADDR_KEY, 32'hba, 0);
    xfer(1'b1, regs_pkg::ADDR_KEY, 32'h11, 0);
    xfer(1'b1, regs_pkg::ADDR_KEY, 32'hbe, 0);
    xfer(1'b1, regs_pkg::ADDR_CONFIG, 32'h06, 0);
    xfer(1'b0, regs_pkg::ADDR_CONFIG, 0, 8'h00);
    xfer(1'b1, regs_pkg::ADDR_KEY, 32'hba, 0);
    xfer(1'b1, regs_pkg::ADDR_KEY, 32'hbe, 0);
    xfer(1'b1, regs_pkg::ADDR_CONFIG, 32'hfe, 0);
    repeat (3) @(negedge clk);
    check(pulses, 1);
    check({24'h0, nvm.data}, {24'h0, v});
    check({31'h0, direct_mode}, 1);
    xfer(1'b1, regs_pkg::ADDR_KEY, 32'h00, 0);
    xfer(1'b1, regs_pkg::ADDR_CONFIG, 32'h00, 0);
    xfer(1'b0, regs_pkg::ADDR_CONFIG, 0, 8'hfe);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, regs_pkg::ADDR_MASK, {24'h0, ~(8'h01 << i)}, 0);
      @(posedge clk) fault_flags <= 8'h01 << i;
      repeat (4) @(negedge clk);
      check({31'h0, irq}, 1);
      xfer(1'b0, regs_pkg::ADDR_STATUS, 0, 8'h01 << i);
      @(posedge clk) fault_flags <= ~(8'h01 << i);
      repeat (4) @(negedge clk);
      check({31'h0, irq}, 0);
    end
    xfer(1'b1, regs_pkg::ADDR_DELAY, 32'h10, 0);
    @(posedge clk) rails_enable <= 1'b1;
    repeat (41) @(negedge clk);
    check({28'h0, rails}, 0);
    repeat (1) @(negedge clk);
    check({28'h0, rails}, 32'hc);
    repeat (79) @(negedge clk);
    check({28'h0, rails}, 32'hc);
    repeat (1) @(negedge clk);
    check({28'h0, rails}, 32'hf);
    @(posedge clk) rails_enable <= 1'b0;
    repeat (2) @(negedge clk);
    check({28'h0, rails}, 0);
    print_verdict();
  end
endmodule : pmic_mask_timing_unlock_regs_test
